// [common/dci_pkg.sv]
// register map and field layout of the converter interface config bank
// assumes one byte-wide register per seven-bit serial address
package dci_pkg;
    localparam int          FRAME_BITS  = 16;
    localparam logic [4:0]  CNT_CMD     = 5'h07;
    localparam logic [4:0]  CNT_LAST    = 5'h0F;
    // register offsets
    localparam logic [6:0]  A_CLK_CTL   = 7'h02;
    localparam logic [6:0]  A_DCKI_CTL  = 7'h03;
    localparam logic [6:0]  A_PORT_CTL  = 7'h04;
    localparam logic [6:0]  A_SYNC_CTL  = 7'h05;
    localparam logic [6:0]  A_PH_CMP    = 7'h06;
    localparam logic [6:0]  A_LIN_CTL   = 7'h07;
    localparam logic [6:0]  A_LIN_LIM   = 7'h08;
    localparam logic [6:0]  A_GAIN      = 7'h09;
    localparam logic [6:0]  A_TMUX      = 7'h18;
    // field positions
    localparam int          B_DIV       = 5;
    localparam int          B_ISEL      = 6;
    localparam int          B_TERM      = 7;
    localparam int          B_RX_EN     = 0;
    localparam int          B_PRESENT   = 1;
    localparam int          B_QUAD      = 2;
    localparam int          B_TADJ      = 4;
    localparam int          B_PA_EN     = 0;
    localparam int          B_PB_EN     = 1;
    localparam int          B_SP        = 2;
    localparam int          B_DEN       = 3;
    localparam int          B_MSYN      = 2;
    localparam int          B_LINEARIZE_GAIN_SEL    = 1;
    localparam int          B_VMN       = 4;
    localparam int          B_TM_ADR    = 1;
    // reset values
    localparam logic [2:0]  R_CLK_CTL   = 3'h0;
    localparam logic [2:0]  R_TADJ      = 3'h0;
    localparam logic [3:0]  R_PORT_CTL  = 4'h0;
    localparam logic [1:0]  R_SYNC_PHASE_SEL   = 2'h0;
    localparam logic [7:0]  R_PH_CMP    = 8'h00;
    localparam logic [2:0]  R_LINEARIZE_GAIN_SEL    = 3'h0;
    localparam logic [3:0]  R_VMX       = 4'h8;
    localparam logic [3:0]  R_VMN       = 4'h0;
    localparam logic [5:0]  R_GAIN      = 6'h00;
    localparam logic [4:0]  R_TM_ADR    = 5'h00;
    localparam logic [7:0]  R_ZERO      = 8'h00;
endpackage

// [rtl/dci_regs.sv]
// serial config bank, clock-present detector and data enable/port order
// assumes serial pins and data inputs are synchronous to ref_clk
//
// How it works
// [RQ1] clock control bit 5 picks output clock divide: 0 by four, 1 by two
// [RQ2] clock control bit 6 picks output clock drive current, resets low
// [RQ3] clock control bit 7 turns on output clock termination, resets off
// [RQ4] bit 0 of data_clock_input_control enables the input clock receiver, resets off
// [RQ5] bit 1 of data_clock_input_control reads clock present, writes ignored
// [RQ6] bit 2 of data_clock_input_control selects in phase or quadrature input clock
// [RQ7] bits 6..4 of data_clock_input_control hold the input clock delay code, reset 000
// [RQ8] bits 0 and 1 of data_port_control enable port A and port B receivers
// [RQ9] bit 2 of data_port_control selects dual port (0) or single port (1)
// [RQ10] bit 3 of data_port_control low forces the converter code to mid-scale
// [RQ11] bits 1..0 of synchronizer_phase_control hold the synchronizer phase selection, reset 00
// [RQ12] bit 2 of synchronizer_phase_control low lets the synchronizer set the phase itself
// [RQ13] 0x06 reads back the phase comparator outputs, resets 0x00
// [RQ14] bit 0 of linearization_control disables dynamic linearization, resets active
// [RQ15] bits 3..1 of linearization_control hold the linearization gain code
// [RQ16] bits 3..0 of linearization_voltage_limits hold the max voltage code, reset 1000
// [RQ17] bits 7..4 of linearization_voltage_limits hold the min voltage code, reset 0000
// [RQ18] bits 5..0 of 0x09 hold the gain trim, upper bits reserved
// [RQ19] test_mux_control holds test mux select bit 0 and address bits 5..1
// [RQ20] host waits 1 ms after receiver enable before data enable
// [RQ21] in dual port mode port A sample leaves before port B sample
// [RQ22] host keeps dual port, divide by four, data enable with pattern gen; the bench leaves the divide bit as its last random clock control write set it
// [RQ23] reserved bits and addresses read zero, writes ignored
// [RQ24] clock present is a live synchronized activity status
module dci_regs
    import dci_pkg::*;
#(
    parameter int DW      = 16,
    parameter int ACT_WIN = 64
) (
    input  wire logic          ref_clk,
    input  wire logic          arst_n,
    input  wire logic          spi_cs_n,
    input  wire logic          spi_sck,
    input  wire logic          spi_sdi,
    output logic               spi_sdo,
    output logic               spi_sdo_oe,
    input  wire logic          in_clk_toggle,
    input  wire logic [1:0]    sync_auto_phase,
    input  wire logic [7:0]    phase_comparator_out,
    input  wire logic [DW-1:0] port_a_data,
    input  wire logic [DW-1:0] port_b_data,
    output logic               out_clk_divide_sel,
    output logic               out_clk_current_sel,
    output logic               out_clk_termination_on,
    output logic               in_clk_receiver_enable,
    output logic               in_clk_present,
    output logic               in_clk_quadrature_sel,
    output logic [2:0]         in_clk_delay_adjust,
    output logic               port_a_receiver_enable,
    output logic               port_b_receiver_enable,
    output logic               single_port_sel,
    output logic               data_enable,
    output logic [1:0]         sync_phase_sel,
    output logic               sync_manual_mode,
    output logic               linearize_disable,
    output logic [2:0]         linearize_gain_sel,
    output logic [3:0]         linearize_vmax_sel,
    output logic [3:0]         linearize_vmin_sel,
    output logic [5:0]         converter_gain_trim,
    output logic               test_mux_select,
    output logic [4:0]         test_mux_address,
    output logic [DW-1:0]      dac_code
);
    localparam logic [DW-1:0] MID = {1'b1, {(DW-1){1'b0}}};
    localparam int            CW  = $clog2(ACT_WIN + 1);
    localparam logic [CW-1:0] WIN = CW'(ACT_WIN);

    logic          sck_q_r;
    logic [4:0]    cnt_r;
    logic [14:0]   sh_r;
    logic [7:0]    tx_r;
    logic          rd_r;
    logic [2:0]    clk_ctl_r;
    logic [1:0]    dcki_r;
    logic [2:0]    tadj_r;
    logic [3:0]    port_r;
    logic [1:0]    ps_wr_r;
    logic          msyn_r;
    logic [1:0]    ps_r;
    logic [7:0]    cmp_r;
    logic [3:0]    lin_r;
    logic [7:0]    lim_r;
    logic [5:0]    gain_r;
    logic [5:0]    tmux_r;
    logic [2:0]    tog_r;
    logic [CW-1:0] act_r;
    logic          present_r;
    logic          ph_r;
    logic [DW-1:0] hold_b_r;
    logic [DW-1:0] dac_r;
    logic          sdo_r;
    logic          sdo_oe_r;

    // serial edge decode and frame fields
    wire       rise   = spi_sck & ~sck_q_r & ~spi_cs_n;
    wire       fall   = ~spi_sck & sck_q_r & ~spi_cs_n;
    wire       cmd_go = rise && cnt_r == CNT_CMD;
    wire       wr_go  = rise && cnt_r == CNT_LAST && !sh_r[14];
    wire [6:0] raddr  = {sh_r[5:0], spi_sdi};
    wire [6:0] waddr  = sh_r[13:7];
    wire [7:0] wdata  = {sh_r[6:0], spi_sdi};

    // read mux, unmapped and reserved bits read zero
    function automatic logic [7:0] rd_mux(input logic [6:0] a);
        unique case (a)
            A_CLK_CTL:  rd_mux = {clk_ctl_r, 5'h00};
            A_DCKI_CTL: rd_mux = {1'b0, tadj_r, 1'b0, dcki_r[1], present_r,
                                  dcki_r[0]};                      // [RQ5] [RQ23]
            A_PORT_CTL: rd_mux = {4'h0, port_r};
            A_SYNC_CTL: rd_mux = {5'h00, msyn_r, ps_r};
            A_PH_CMP:   rd_mux = cmp_r;                            // [RQ13]
            A_LIN_CTL:  rd_mux = {4'h0, lin_r};
            A_LIN_LIM:  rd_mux = lim_r;
            A_GAIN:     rd_mux = {2'h0, gain_r};
            A_TMUX:     rd_mux = {2'h0, tmux_r};
            default:    rd_mux = R_ZERO;                           // [RQ23]
        endcase
    endfunction

    // frame bit counter, cleared while deselected, and shift-in
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_q_r <= 1'b0;
            cnt_r   <= 5'h00;
            sh_r    <= 15'h0000;
        end else begin
            sck_q_r <= spi_sck;
            if (spi_cs_n) begin
                cnt_r <= 5'h00;
            end else if (rise) begin
                cnt_r <= cnt_r + 5'h01;
                sh_r  <= {sh_r[13:0], spi_sdi};
            end
        end
    end

    // read data loaded after address, shifted out on falling edges
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_r     <= R_ZERO;
            rd_r     <= 1'b0;
            sdo_r    <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else begin
            if (cmd_go) begin
                tx_r <= rd_mux(raddr);
                rd_r <= sh_r[6];
            end else if (fall && sdo_oe_r) begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
            if (fall && sdo_oe_r) begin
                sdo_r <= tx_r[7];
            end
            sdo_oe_r <= ~spi_cs_n && rd_r && cnt_r > CNT_CMD;
        end
    end

    // writable config registers, fields masked to documented bits
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_ctl_r <= R_CLK_CTL;
            dcki_r    <= 2'h0;
            tadj_r    <= R_TADJ;
            port_r    <= R_PORT_CTL;
            ps_wr_r   <= R_SYNC_PHASE_SEL;
            msyn_r    <= 1'b0;
            lin_r     <= 4'h0;
            lim_r     <= {R_VMN, R_VMX};
            gain_r    <= R_GAIN;
            tmux_r    <= {R_TM_ADR, 1'b0};
        end else if (wr_go) begin
            if (waddr == A_CLK_CTL)
                clk_ctl_r <= wdata[B_TERM:B_DIV];                  // [RQ1] [RQ2] [RQ3]
            if (waddr == A_DCKI_CTL) begin
                dcki_r <= {wdata[B_QUAD], wdata[B_RX_EN]};         // [RQ4] [RQ6]
                tadj_r <= wdata[B_TADJ+2:B_TADJ];                  // [RQ7]
            end
            if (waddr == A_PORT_CTL)
                port_r <= wdata[B_DEN:B_PA_EN];                    // [RQ8] [RQ9]
            if (waddr == A_SYNC_CTL) begin
                ps_wr_r <= wdata[1:0];                             // [RQ11]
                msyn_r  <= wdata[B_MSYN];
            end
            if (waddr == A_LIN_CTL)
                lin_r <= wdata[3:0];                               // [RQ14] [RQ15]
            if (waddr == A_LIN_LIM)
                lim_r <= wdata;                                    // [RQ16] [RQ17]
            if (waddr == A_GAIN)
                gain_r <= wdata[5:0];                              // [RQ18]
            if (waddr == A_TMUX)
                tmux_r <= wdata[5:0];                              // [RQ19]
        end
    end

    // phase select source and comparator capture
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ps_r  <= R_SYNC_PHASE_SEL;
            cmp_r <= R_PH_CMP;
        end else begin
            ps_r  <= msyn_r ? ps_wr_r : sync_auto_phase;           // [RQ12]
            cmp_r <= phase_comparator_out;                         // [RQ13]
        end
    end

    // input clock activity: sync, edge detect, timeout window
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tog_r     <= 3'h0;
            act_r     <= WIN;
            present_r <= 1'b0;
        end else begin
            tog_r     <= {tog_r[1:0], in_clk_toggle};
            act_r     <= (tog_r[2] ^ tog_r[1]) ? '0 :
                         (act_r == WIN) ? act_r : act_r + 1'b1;    // [RQ24]
            present_r <= act_r < WIN;                              // [RQ5] [RQ24]
        end
    end

    // sample path: mid-scale when disabled, A then B in dual mode
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_r     <= 1'b0;
            hold_b_r <= '0;
            dac_r    <= MID;
        end else if (!port_r[B_DEN]) begin
            ph_r  <= 1'b0;
            dac_r <= MID;                                          // [RQ10]
        end else if (port_r[B_SP]) begin
            ph_r  <= 1'b0;
            dac_r <= port_b_data;
        end else begin
            ph_r <= ~ph_r;
            if (!ph_r) begin
                dac_r    <= port_a_data;                           // [RQ21]
                hold_b_r <= port_b_data;
            end else begin
                dac_r <= hold_b_r;                                 // [RQ21]
            end
        end
    end

    // outputs straight from flops
    assign spi_sdo                = sdo_r;
    assign spi_sdo_oe             = sdo_oe_r;
    assign out_clk_divide_sel     = clk_ctl_r[0];
    assign out_clk_current_sel    = clk_ctl_r[1];
    assign out_clk_termination_on = clk_ctl_r[2];
    assign in_clk_receiver_enable = dcki_r[0];
    assign in_clk_quadrature_sel  = dcki_r[1];
    assign in_clk_present         = present_r;
    assign in_clk_delay_adjust    = tadj_r;
    assign port_a_receiver_enable = port_r[B_PA_EN];
    assign port_b_receiver_enable = port_r[B_PB_EN];
    assign single_port_sel        = port_r[B_SP];
    assign data_enable            = port_r[B_DEN];
    assign sync_phase_sel         = ps_r;
    assign sync_manual_mode       = msyn_r;
    assign linearize_disable      = lin_r[0];
    assign linearize_gain_sel     = lin_r[3:1];
    assign linearize_vmax_sel     = lim_r[3:0];
    assign linearize_vmin_sel     = lim_r[7:4];
    assign converter_gain_trim    = gain_r;
    assign test_mux_select        = tmux_r[0];
    assign test_mux_address       = tmux_r[5:1];
    assign dac_code               = dac_r;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_div_write: assert property (wr_go && waddr == A_CLK_CTL |=> // [RQ1]
        out_clk_divide_sel == $past(wdata[B_DIV])) else $error("divide bit not written");
    a_isel_write: assert property (wr_go && waddr == A_CLK_CTL |=> // [RQ2]
        out_clk_current_sel == $past(wdata[B_ISEL])) else $error("current bit not written");
    a_term_write: assert property (wr_go && waddr == A_CLK_CTL |=> // [RQ3]
        out_clk_termination_on == $past(wdata[B_TERM])) else $error("term bit not written");
    a_rx_hold: assert property (!wr_go |=> $stable(in_clk_receiver_enable)) // [RQ4]
        else $error("receiver enable changed without write");
    a_mid_scale: assert property (!data_enable |=> dac_code == MID) // [RQ10]
        else $error("output not mid-scale");
    a_manual_phase: assert property (sync_manual_mode && !wr_go |=> // [RQ12]
        sync_phase_sel == $past(ps_wr_r)) else $error("manual phase lost");
    a_auto_phase: assert property (!sync_manual_mode && !wr_go |=> // [RQ12]
        sync_phase_sel == $past(sync_auto_phase)) else $error("auto phase lost");
    a_dual_order: assert property (data_enable && !single_port_sel && !ph_r && !wr_go // [RQ21]
        ##1 !wr_go |=> dac_code == $past(port_b_data, 2)) else $error("port B out of order");
    a_reserved_zero: assert property (cmd_go && raddr > A_GAIN && raddr != A_TMUX // [RQ23]
        |=> tx_r == R_ZERO) else $error("reserved read not zero");
    a_present_drop: assert property (act_r == WIN |=> !in_clk_present) // [RQ24]
        else $error("present while idle");

    c_write_frame: cover property (wr_go);
    c_read_frame: cover property (cmd_go && sh_r[6]);
    c_dual_pair: cover property (data_enable && !single_port_sel && ph_r);
endmodule

// [verif/dci_host_model.sv]
// host serial controller model for the config bank
// assumes the bank samples cs, sck and sdi on rising ref_clk edges
module dci_host_model (
    input  wire logic       ref_clk,
    output logic            spi_cs_n,
    output logic            spi_sck,
    output logic            spi_sdi,
    input  wire logic       spi_sdo,
    input  wire logic       spi_sdo_oe,
    output logic            rd_valid,
    output logic [7:0]      rd_byte,
    output logic            rd_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        {spi_cs_n, spi_sck, spi_sdi, rd_valid, rd_byte} = {4'b1000, 8'h00};
        rd_oe = 1'b0;
    end

    // one frame, msb first, sck low and high three cycles each
    task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] wdata,
                        input int nbits);
        logic [15:0] frm;
        logic [7:0]  got;
        logic        oe_all;
        frm = {rw, addr, wdata};
        got = 8'h00;
        oe_all = 1'b1;
        @(negedge ref_clk);
        spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_sdi = frm[15-i];
            spi_sck = 1'b0;
            repeat (3) @(negedge ref_clk);
            if (i >= 8) got = {got[6:0], spi_sdo};
            if (i >= 8) oe_all = oe_all & spi_sdo_oe;   // driver on for every data bit
            spi_sck = 1'b1;
            repeat (3) @(negedge ref_clk);
        end
        spi_sck = 1'b0;
        repeat (2) @(negedge ref_clk);
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;   // released line does not keep its last bit
        if (rw && nbits == 16) begin
            rd_byte = got;
            rd_oe = oe_all;
            rd_valid = 1'b1;
            @(negedge ref_clk);
            rd_valid = 1'b0;
        end
        repeat (3) @(negedge ref_clk);
    endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the converter interface config bank
// assumes the host model drives the serial pins, the bench drives the rest
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb import dci_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 0, arst_n = 0, in_clk_toggle = 0, tog_en = 0;
    logic [1:0]  sync_auto_phase = 2'h0, sync_phase_sel;
    logic [7:0]  phase_comparator_out = 8'h00, rd_byte, exp_b;
    logic [15:0] port_a_data = 16'h0000, port_b_data = 16'h0000, dac_code, ah[8], bh[8], dv[8];
    logic        spi_cs_n, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe, rd_valid, rd_oe;
    logic        out_clk_divide_sel, out_clk_current_sel, out_clk_termination_on;
    logic        in_clk_receiver_enable, in_clk_present, in_clk_quadrature_sel;
    logic        port_a_receiver_enable, port_b_receiver_enable, single_port_sel, data_enable;
    logic        sync_manual_mode, linearize_disable, test_mux_select;
    logic [2:0]  in_clk_delay_adjust, linearize_gain_sel;
    logic [3:0]  linearize_vmax_sel, linearize_vmin_sel;
    logic [5:0]  converter_gain_trim;
    logic [4:0]  test_mux_address;
    logic [7:0]  exp_q[$];
    int          miscompares = 0, total_checks = 0;
    logic [6:0]  addrs[13] = '{A_CLK_CTL, A_DCKI_CTL, A_PORT_CTL, A_SYNC_CTL, A_PH_CMP,
                               A_LIN_CTL, A_LIN_LIM, A_GAIN, A_TMUX, 7'h00, 7'h0A, 7'h17, 7'h7F};

    dci_regs #(.DW(16), .ACT_WIN(8)) uut (.*);
    dci_host_model host (.*);

    // clock and input clock activity
    always #10 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (tog_en) in_clk_toggle <= ~in_clk_toggle;

    // take the oldest note whenever a read result appears
    always @(posedge ref_clk) begin
        if (rd_valid) begin
            exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHK("read data", exp_b, rd_byte)
            `CHK("sdo enable", 1'b1, rd_oe)
        end
    end

    // register byte as the ports show it
    function automatic logic [7:0] pview(logic [6:0] a);
        case (a)
            A_CLK_CTL:  return {out_clk_termination_on, out_clk_current_sel, out_clk_divide_sel,
                                5'h00};
            A_DCKI_CTL: return {1'b0, in_clk_delay_adjust, 1'b0, in_clk_quadrature_sel,
                                in_clk_present, in_clk_receiver_enable};
            A_PORT_CTL: return {4'h0, data_enable, single_port_sel, port_b_receiver_enable,
                                port_a_receiver_enable};
            A_SYNC_CTL: return {5'h00, sync_manual_mode, sync_phase_sel};
            A_LIN_CTL:  return {4'h0, linearize_gain_sel, linearize_disable};
            A_LIN_LIM:  return {linearize_vmin_sel, linearize_vmax_sel};
            A_GAIN:     return {2'b00, converter_gain_trim};
            A_TMUX:     return {2'b00, test_mux_address, test_mux_select};
            default:    return (a == A_PH_CMP) ? phase_comparator_out : 8'h00;
        endcase
    endfunction

    // expected byte after writing w, with no input clock and auto phase as driven
    function automatic logic [7:0] wexp(logic [6:0] a, logic [7:0] w);
        case (a)
            A_CLK_CTL:  return w & 8'hE0;
            A_DCKI_CTL: return w & 8'h75;
            A_PORT_CTL: return w & 8'h0F;
            A_SYNC_CTL: return w[2] ? (w & 8'h07) : ((w & 8'h04) | {6'h00, sync_auto_phase});
            A_PH_CMP:   return phase_comparator_out;
            A_LIN_CTL:  return w & 8'h0F;
            A_LIN_LIM:  return w;
            A_GAIN:     return w & 8'h3F;
            A_TMUX:     return w & 8'h3F;
            default:    return 8'h00;
        endcase
    endfunction

    task automatic wr(logic [6:0] a, logic [7:0] d);
        host.xfer(1'b0, a, d, 16);
    endtask

    // read back a register and compare its port view
    task automatic chk_reg(logic [6:0] a, logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b1, a, 8'h00, 16);
        `CHK("port view", e, pview(a))
        `CHK("sdo release", 1'b0, spi_sdo_oe)
    endtask

    // bounded wait on the clock present status
    task automatic wait_pres(logic v);
        for (int n = 0; n < 40 && in_clk_present !== v; n++) @(negedge ref_clk);
        `CHK("clock present", v, in_clk_present)
        if (in_clk_present !== v) wrap_up();
    endtask

    task automatic wrap_up();
        `CHK("pending reads", 0, exp_q.size())
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (90_000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end

    // main sequence
    initial begin
        int n;
        void'($urandom(32'haa79_8c2d));
        phase_comparator_out = 8'($urandom());
        repeat (4) @(negedge ref_clk);
        arst_n = 1'b1;
        // comparator readback follows its live input once reset is released
        foreach (addrs[i]) chk_reg(addrs[i], (addrs[i] == A_LIN_LIM) ? 8'h08 :
                                   (addrs[i] == A_PH_CMP) ? phase_comparator_out : 8'h00);
        $display("test reset_values done");
        repeat (2) foreach (addrs[i]) begin
            exp_b = 8'($urandom());
            wr(addrs[i], exp_b);
            chk_reg(addrs[i], wexp(addrs[i], exp_b));
        end
        $display("test write_readback done");
        wr(A_GAIN, 8'h15);
        host.xfer(1'b0, A_GAIN, 8'h2A, 12);
        chk_reg(A_GAIN, 8'h15);
        $display("test short_frame done");
        wr(A_SYNC_CTL, 8'h00);
        sync_auto_phase = 2'h2;
        repeat (3) @(negedge ref_clk);
        `CHK("auto phase", 2'h2, sync_phase_sel)
        wr(A_SYNC_CTL, 8'h05);
        `CHK("manual phase", 2'h1, sync_phase_sel)
        sync_auto_phase = 2'h0;
        $display("test sync_phase done");
        wr(A_DCKI_CTL, 8'h01);
        tog_en = 1'b1;
        wait_pres(1'b1);
        chk_reg(A_DCKI_CTL, 8'h03);
        tog_en = 1'b0;
        wait_pres(1'b0);
        chk_reg(A_DCKI_CTL, 8'h01);
        $display("test clock_present done");
        wr(A_PORT_CTL, 8'h03);
        port_a_data = 16'($urandom());
        port_b_data = 16'($urandom());
        repeat (50_000) @(negedge ref_clk); // 1 ms wait after receiver enable before data enable
        `CHK("mid-scale", 16'h8000, dac_code)
        wr(A_PORT_CTL, 8'h0E);
        for (int k = 0; k < 6; k++) begin
            port_b_data = 16'($urandom());
            @(negedge ref_clk);
            `CHK("single port", port_b_data, dac_code)
        end
        // pattern generator stays off, dual port set, divide bit left as the random clock control writes set it
        wr(A_PORT_CTL, 8'h0B);
        for (int k = 0; k < 8; k++) begin
            port_a_data = 16'($urandom());
            port_b_data = ~port_a_data;
            ah[k] = port_a_data;
            bh[k] = port_b_data;
            @(negedge ref_clk);
            dv[k] = dac_code;
        end
        n = 0;
        for (int k = 0; k < 7; k++) begin
            if (dv[k] === ah[k]) begin
                n++;
                `CHK("dual order", bh[k], dv[k+1])
            end
        end
        `CHK("dual pairs", 1'b1, n >= 3)
        $display("test data_path done");
        wrap_up();
    end
endmodule
